// ==== apic_map.svh ====
`ifndef APIC_MAP_SVH
`define APIC_MAP_SVH
`define APIC_CLK_HZ        10000000
`define APIC_BLINK_MS      500
`define APIC_BLINK_CYC     ((`APIC_CLK_HZ / 1000) * `APIC_BLINK_MS)
`define APIC_DEB_MS        10
`define APIC_DEB_CYC       ((`APIC_CLK_HZ / 1000) * `APIC_DEB_MS)
`define APIC_PSU_LO_MV     24500
`define APIC_PSU_HI_MV     28000
`define APIC_IDX_RST       8'h00
`endif

// ==== apic_pkg.sv ====
package apic_pkg;
	typedef struct packed {
		logic isolate_bell;
		logic isolate_warn;
		logic isolate_fault;
		logic isolate_aux;
		logic investigate;
		logic prev;
		logic next;
		logic ack;
		logic reset;
		logic deisolate;
	} apic_keys_t;

	typedef struct packed {
		logic alarm;
		logic fault;
		logic isolate;
		logic bell_iso;
		logic warn_iso;
		logic fault_iso;
		logic aux_iso;
		logic aux_fault;
		logic investigate;
		logic warn_fault;
		logic earth;
		logic cpu_fault;
		logic aux_alarm;
		logic psu_fault;
		logic pre_alarm;
		logic test;
	} apic_leds_t;

	typedef enum logic [1:0] {
		APIC_BRD_MEASURE,
		APIC_BRD_REPORT,
		APIC_BRD_WAIT,
		APIC_BRD_RUN
	} apic_brd_state_t;

	typedef struct packed {
		apic_leds_t      leds;
		logic            buzzer;
		logic            buzz_silenced;
		logic [7:0]      index;
		logic            ack_pulse;
		logic            rst_pulse;
		logic            deiso_pulse;
		logic [7:0]      to_main;
		logic            to_main_full;
		logic [15:0]     from_main;
		logic            from_main_bytes;
		logic            from_main_half;
		logic [7:0]      board_type;
		logic            type_valid;
		apic_brd_state_t brd;
		logic            running;
	} apic_state_t;
endpackage

// ==== apic_debounce.sv ====
`include "apic_map.svh"
module apic_debounce #(
	parameter int N   = 10,
	parameter int CYC = `APIC_DEB_CYC
) (
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Raw keys and one-cycle press events.
	input  wire logic [N-1:0] raw_in,
	output logic      [N-1:0] press_out
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] stable;
		logic [N-1:0] press;
		logic [23:0]  cnt;
	} apic_deb_t;

	apic_deb_t st_reg;
	apic_deb_t st_next;

	// ===========================================================================
	// Synchroniser and filter
	// ===========================================================================
	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.press = '0;
		if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.stable) begin
			if (st_reg.cnt >= 24'(CYC - 1)) begin
				st_next.stable = st_reg.s3;
				st_next.press = st_reg.s3 & ~st_reg.stable;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt + 24'h00_0001;
			end
		end else begin
			st_next.cnt = '0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign press_out = st_reg.press;
endmodule

// ==== apic_panel.sv ====
// Operation
// - Alarm LED flashes with unacknowledged alarms, steady when all acknowledged.
// - Fault LED steady whenever any fault is present.
// - Isolate LED steady whenever anything is isolated.
// - Bell isolate key toggles bell isolation; LED steady while isolated.
// - Warning-system isolate key toggles that output's isolation; LED shows it.
// - Previous and next keys step the displayed entry index.
// - Acknowledge key acknowledges displayed alarm and silences buzzer.
// - Reset key clears acknowledged alarms and returns display to default.
// - Power fault LED on mains loss, battery fault, or voltage out of range.
// - Pre-alarm LED lit while any sensor is in pre-alarm.
// - Test LED lit while in any test mode.
// - De-isolate key returns displayed isolated detector to service.
// - Fault-output isolate key toggles fault relay isolation; LED shows it.
// - Aux relay isolated by key or open door; key press de-isolates only while the door is closed.
// - Aux LED flashes while monitored aux line reports fault.
// - Investigation key activates investigation facility and its LED.
// - Warning-system fault LED lit when that connection is faulty.
// - Earth fault and processor fault LEDs follow their conditions.
// - Aux alarm LED lit while aux alarm output is active.
// - Byte bus: one byte held toward main, two bytes from main.
// - Measure type voltage, report type, await start, then run.
`include "apic_map.svh"
module apic_panel #(
	parameter int BLINK_CYC = `APIC_BLINK_CYC,
	parameter int DEB_CYC   = `APIC_DEB_CYC
) (
	// Clock and reset.
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Keypad.
	input  wire apic_pkg::apic_keys_t keys_in,
	// System conditions from the processor side.
	input  wire logic                 alarm_any_in,
	input  wire logic                 alarm_unacked_in,
	input  wire logic                 fault_any_in,
	input  wire logic                 isolated_any_in,
	input  wire logic                 displayed_iso_in,
	input  wire logic                 buzz_on_alarm_in,
	input  wire logic                 mains_ok_in,
	input  wire logic                 battery_ok_in,
	input  wire logic [15:0]          psu_mv_in,
	input  wire logic                 pre_alarm_in,
	input  wire logic                 test_mode_in,
	input  wire logic                 door_open_in,
	input  wire logic                 aux_line_fault_in,
	input  wire logic                 warn_link_fault_in,
	input  wire logic                 earth_fault_in,
	input  wire logic                 cpu_fault_in,
	input  wire logic                 aux_alarm_in,
	// Main processor byte bus.
	input  wire logic [7:0]           bus_wdata_in,
	input  wire logic                 bus_write_in,
	input  wire logic                 bus_read_in,
	input  wire logic                 bus_start_in,
	input  wire logic [7:0]           slave_byte_in,
	input  wire logic                 slave_write_in,
	input  wire logic                 slave_take_in,
	// Board type sensing.
	input  wire logic [7:0]           type_adc_in,
	input  wire logic                 type_adc_valid_in,
	// Indicators and buzzer.
	output apic_pkg::apic_leds_t      leds_out,
	output logic                      buzzer_out,
	// Display control toward the processor.
	output logic [7:0]                index_out,
	output logic                      ack_out,
	output logic                      reset_out,
	output logic                      deisolate_out,
	// Byte bus data.
	output logic [7:0]                to_main_out,
	output logic                      to_main_full_out,
	output logic [15:0]               from_main_out,
	output logic                      from_main_ready_out,
	// Board state.
	output logic [7:0]                board_type_out,
	output logic                      type_valid_out,
	output logic                      running_out
);
	import apic_pkg::*;

	apic_state_t st_reg;
	apic_state_t st_next;
	logic [9:0]  press;
	apic_keys_t  ev;
	logic [23:0] blink_cnt_reg;
	logic [23:0] blink_cnt_next;
	logic        blink_reg;
	logic        blink_next;
	logic        d1_reg;
	logic        d2_reg;
	logic        d3_reg;
	logic        door_reg;

	function automatic logic out_of_range(input logic [15:0] mv);
		return (mv < 16'(`APIC_PSU_LO_MV)) || (mv > 16'(`APIC_PSU_HI_MV));
	endfunction

	// ===========================================================================
	// Key events
	// ===========================================================================
	apic_debounce #(
		.N   (10),
		.CYC (DEB_CYC)
	) u_deb (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.raw_in    (keys_in),
		.press_out (press)
	);
	assign ev = apic_keys_t'(press);

	// ===========================================================================
	// Blink and door synchroniser
	// ===========================================================================
	// shared blink divider
	always_comb begin
		blink_cnt_next = blink_cnt_reg + 24'h00_0001;
		blink_next = blink_reg;
		if (blink_cnt_reg >= 24'(BLINK_CYC - 1)) begin
			blink_cnt_next = '0;
			blink_next = ~blink_reg;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			blink_cnt_reg <= '0;
			blink_reg <= 1'b0;
			d1_reg <= 1'b0;
			d2_reg <= 1'b0;
			d3_reg <= 1'b0;
			door_reg <= 1'b0;
		end else begin
			blink_cnt_reg <= blink_cnt_next;
			blink_reg <= blink_next;
			d1_reg <= door_open_in;
			d2_reg <= d1_reg;
			d3_reg <= d2_reg;
			if (d2_reg == d3_reg) begin
				door_reg <= d3_reg;
			end
		end
	end

	// ===========================================================================
	// Panel state
	// ===========================================================================
	always_comb begin
		st_next = st_reg;
		st_next.ack_pulse = 1'b0;
		st_next.rst_pulse = 1'b0;
		st_next.deiso_pulse = 1'b0;

		st_next.leds.alarm = alarm_unacked_in ? blink_reg : alarm_any_in;
		st_next.leds.fault = fault_any_in;
		st_next.leds.isolate = isolated_any_in;
		st_next.leds.psu_fault = ~mains_ok_in | ~battery_ok_in | out_of_range(psu_mv_in);
		st_next.leds.pre_alarm = pre_alarm_in;
		st_next.leds.test = test_mode_in;
		st_next.leds.aux_fault = aux_line_fault_in & blink_reg;
		st_next.leds.warn_fault = warn_link_fault_in;
		st_next.leds.earth = earth_fault_in;
		st_next.leds.cpu_fault = cpu_fault_in;
		st_next.leds.aux_alarm = aux_alarm_in;

		if (ev.isolate_bell) begin
			st_next.leds.bell_iso = ~st_reg.leds.bell_iso;
		end
		if (ev.isolate_warn) begin
			st_next.leds.warn_iso = ~st_reg.leds.warn_iso;
		end
		if (ev.isolate_fault) begin
			st_next.leds.fault_iso = ~st_reg.leds.fault_iso;
		end
		// aux isolate by key or door
		if (ev.isolate_aux) begin
			st_next.leds.aux_iso = ~st_reg.leds.aux_iso;
		end
		if (door_reg) begin
			st_next.leds.aux_iso = 1'b1;
		end
		if (ev.investigate) begin
			st_next.leds.investigate = 1'b1;
		end

		if (ev.next && !ev.prev) begin
			st_next.index = st_reg.index + 8'h01;
		end else if (ev.prev && !ev.next) begin
			st_next.index = st_reg.index - 8'h01;
		end

		if (ev.ack) begin
			st_next.ack_pulse = 1'b1;
			st_next.buzz_silenced = 1'b1;
		end
		if (ev.reset) begin
			st_next.rst_pulse = 1'b1;
			st_next.index = `APIC_IDX_RST;
			st_next.leds.investigate = 1'b0;
		end
		if (ev.deisolate && displayed_iso_in) begin
			st_next.deiso_pulse = 1'b1;
		end

		// An unacknowledged alarm re-arms the buzzer after a silence only while alarm_any_in and the alarm lamp are both low.
		if (alarm_unacked_in && !ev.ack && !st_reg.leds.alarm && !alarm_any_in) begin
			st_next.buzz_silenced = 1'b0;
		end
		if (!fault_any_in && !alarm_unacked_in) begin
			st_next.buzz_silenced = 1'b0;
		end
		st_next.buzzer = (fault_any_in | (buzz_on_alarm_in & alarm_unacked_in)) & ~st_next.buzz_silenced;

		if (slave_write_in && !st_reg.to_main_full) begin
			st_next.to_main = slave_byte_in;
			st_next.to_main_full = 1'b1;
		end
		if (bus_read_in) begin
			st_next.to_main_full = 1'b0;
		end
		if (bus_write_in && !(st_reg.from_main_bytes && !slave_take_in)) begin
			st_next.from_main = {st_reg.from_main[7:0], bus_wdata_in};
		end
		// A byte accepted with the take strobe starts the next pair, so it is not lost.
		if (slave_take_in) begin
			st_next.from_main_bytes = 1'b0;
			st_next.from_main_half = bus_write_in & st_reg.running;
		end else if (bus_write_in && st_reg.running && !st_reg.from_main_bytes) begin
			st_next.from_main_bytes = st_reg.from_main_half;
			st_next.from_main_half = ~st_reg.from_main_half;
		end

		unique case (st_reg.brd)
			APIC_BRD_MEASURE: begin
				if (type_adc_valid_in) begin
					st_next.board_type = type_adc_in;
					st_next.brd = APIC_BRD_REPORT;
				end
			end
			APIC_BRD_REPORT: begin
				st_next.type_valid = 1'b1;
				st_next.brd = APIC_BRD_WAIT;
			end
			APIC_BRD_WAIT: begin
				if (bus_start_in) begin
					st_next.brd = APIC_BRD_RUN;
					st_next.running = 1'b1;
				end
			end
			APIC_BRD_RUN: begin
				st_next.running = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ===========================================================================
	// Outputs
	// ===========================================================================
	assign leds_out            = st_reg.leds;
	assign buzzer_out          = st_reg.buzzer;
	assign index_out           = st_reg.index;
	assign ack_out             = st_reg.ack_pulse;
	assign reset_out           = st_reg.rst_pulse;
	assign deisolate_out       = st_reg.deiso_pulse;
	assign to_main_out         = st_reg.to_main;
	assign to_main_full_out    = st_reg.to_main_full;
	assign from_main_out       = st_reg.from_main;
	assign from_main_ready_out = st_reg.from_main_bytes;
	assign board_type_out      = st_reg.board_type;
	assign type_valid_out      = st_reg.type_valid;
	assign running_out         = st_reg.running;
endmodule

// ==== apic_panel_chk.sv ====
`include "apic_map.svh"
module apic_panel_chk #(
	parameter int BLINK_CYC = 4
) (
	// Clock and reset.
	input wire logic                 clk_in,
	input wire logic                 rst_in,
	// Watched inputs.
	input wire logic                 alarm_any_in,
	input wire logic                 alarm_unacked_in,
	input wire logic                 fault_any_in,
	input wire logic                 mains_ok_in,
	input wire logic                 battery_ok_in,
	input wire logic [15:0]          psu_mv_in,
	input wire logic                 door_open_in,
	input wire logic                 aux_line_fault_in,
	input wire logic                 bus_start_in,
	input wire logic                 bus_read_in,
	input wire logic                 slave_write_in,
	// Watched outputs.
	input wire apic_pkg::apic_leds_t leds_out,
	input wire logic                 buzzer_out,
	input wire logic                 ack_out,
	input wire logic [7:0]           to_main_out,
	input wire logic                 to_main_full_out,
	input wire logic                 running_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import apic_pkg::*;
	logic       psu_bad;
	logic [7:0] on_cnt_reg;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	assign psu_bad = !mains_ok_in || !battery_ok_in || psu_mv_in < 16'(`APIC_PSU_LO_MV)
		|| psu_mv_in > 16'(`APIC_PSU_HI_MV);
	// A lamp stuck on is only visible as a run longer than half a blink.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			on_cnt_reg <= 8'h00;
		end else begin
			on_cnt_reg <= leds_out.aux_fault ? on_cnt_reg + 8'h01 : 8'h00;
		end
	end
	// ====================================================
	// Lamp and control checks
	// steady when acked
	property p_alarm; alarm_any_in && !alarm_unacked_in |=> leds_out.alarm; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm lamp not steady");
	property p_fault; fault_any_in |=> leds_out.fault; endproperty
	a_fault: assert property (p_fault) else $error("fault lamp not lit");
	property p_psu; 1'b1 |=> leds_out.psu_fault == $past(psu_bad); endproperty
	a_psu: assert property (p_psu) else $error("supply lamp wrong");
	property p_blink; on_cnt_reg <= 8'(BLINK_CYC); endproperty
	a_blink: assert property (p_blink) else $error("aux lamp lit too long");
	property p_auxf; !aux_line_fault_in |=> !leds_out.aux_fault; endproperty
	a_auxf: assert property (p_auxf) else $error("aux lamp without line fault");
	property p_door; door_open_in [*6] |=> leds_out.aux_iso; endproperty
	a_door: assert property (p_door) else $error("open door did not isolate");
	property p_ack; ack_out |-> ##[0:1] !buzzer_out; endproperty
	a_ack: assert property (p_ack) else $error("buzzer not silenced");
	property p_start; $rose(running_out) |-> $past(bus_start_in); endproperty
	a_start: assert property (p_start) else $error("run without start");
	property p_full; slave_write_in && to_main_full_out && !bus_read_in |=> $stable(to_main_out); endproperty
	a_full: assert property (p_full) else $error("full byte overwritten");
endmodule

bind apic_panel apic_panel_chk #(.BLINK_CYC(BLINK_CYC)) chk (.clk_in, .rst_in, .alarm_any_in, .alarm_unacked_in,
	.fault_any_in, .mains_ok_in, .battery_ok_in, .psu_mv_in, .door_open_in, .aux_line_fault_in, .bus_start_in,
	.bus_read_in, .slave_write_in, .leds_out, .buzzer_out, .ack_out, .to_main_out, .to_main_full_out, .running_out);

// ==== apic_host_model.sv ====
module apic_host_model (
	// Clock.
	input  wire logic            clk_in,
	// Keypad levels.
	output apic_pkg::apic_keys_t keys_out,
	// Strobes and shared data toward the panel.
	output logic [5:0]           stb_out,
	output logic [7:0]           data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import apic_pkg::*;
	initial begin
		keys_out = '0;
		stb_out = '0;
		data_out = '0;
	end
	task automatic press(input int b, input int hold);
		keys_out[b] = 1'b1;
		repeat (hold) @(negedge clk_in);
		keys_out[b] = 1'b0;
		repeat (hold) @(negedge clk_in);
	endtask
	// single strobes
	// Data goes to its inverse once the strobe drops, so a late capture shows up.
	task automatic strobe(input int s, input logic [7:0] d);
		data_out = d;
		stb_out[s] = 1'b1;
		@(negedge clk_in);
		stb_out[s] = 1'b0;
		data_out = ~d;
		@(negedge clk_in);
	endtask
endmodule

// ==== apic_panel_tb.sv ====
`include "apic_map.svh"
module apic_panel_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import apic_pkg::*;
	logic clk_in, rst_in, alarm_any_in, alarm_unacked_in, fault_any_in, isolated_any_in, displayed_iso_in;
	logic buzz_on_alarm_in, mains_ok_in, battery_ok_in, pre_alarm_in, test_mode_in, door_open_in;
	logic aux_line_fault_in, warn_link_fault_in, earth_fault_in, cpu_fault_in, aux_alarm_in;
	logic [15:0] psu_mv_in, from_main_out;
	logic buzzer_out, ack_out, reset_out, deisolate_out, to_main_full_out, from_main_ready_out;
	logic type_valid_out, running_out;
	logic [7:0] index_out, to_main_out, board_type_out;
	apic_leds_t leds_out;
	wire apic_keys_t keys_in;
	wire logic [7:0] hd;
	wire logic [5:0] stb;
	wire logic [7:0] bus_wdata_in = hd;
	wire logic [7:0] slave_byte_in = hd;
	wire logic [7:0] type_adc_in = hd;
	wire logic bus_write_in = stb[0];
	wire logic bus_read_in = stb[1];
	wire logic bus_start_in = stb[2];
	wire logic slave_write_in = stb[3];
	wire logic slave_take_in = stb[4];
	wire logic type_adc_valid_in = stb[5];
	int n_fail, checked, cyc, n;
	int pc[3] = '{0, 0, 0};
	int lmap[8] = '{3, 4, 5, 6, 0, 1, 13, 14};
	int mvt[4] = '{24499, 24500, 28000, 28001};

	apic_panel #(.BLINK_CYC(4), .DEB_CYC(2)) dut (.clk_in, .rst_in, .keys_in, .alarm_any_in, .alarm_unacked_in,
		.fault_any_in, .isolated_any_in, .displayed_iso_in, .buzz_on_alarm_in, .mains_ok_in, .battery_ok_in,
		.psu_mv_in, .pre_alarm_in, .test_mode_in, .door_open_in, .aux_line_fault_in, .warn_link_fault_in,
		.earth_fault_in, .cpu_fault_in, .aux_alarm_in, .bus_wdata_in, .bus_write_in, .bus_read_in, .bus_start_in,
		.slave_byte_in, .slave_write_in, .slave_take_in, .type_adc_in, .type_adc_valid_in, .leds_out, .buzzer_out,
		.index_out, .ack_out, .reset_out, .deisolate_out, .to_main_out, .to_main_full_out, .from_main_out,
		.from_main_ready_out, .board_type_out, .type_valid_out, .running_out);
	apic_host_model host (.clk_in(clk_in), .keys_out(keys_in), .stb_out(stb), .data_out(hd));

	// ====================================================
	// Helpers
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	task automatic set_cond(input logic [7:0] c);
		{fault_any_in, isolated_any_in, pre_alarm_in, test_mode_in} = c[7:4];
		{warn_link_fault_in, earth_fault_in, cpu_fault_in, aux_alarm_in} = c[3:0];
	endtask
	// Sixteen cycles span two whole blinks, so a flashing lamp is lit for exactly eight.
	task automatic lit(input int b, output int k);
		k = 0;
		repeat (16) begin
			@(negedge clk_in);
			k += int'(leds_out[b] === 1'b1);
		end
	endtask
	always @(posedge clk_in) begin
		pc[0] += int'(ack_out === 1'b1);
		pc[1] += int'(reset_out === 1'b1);
		pc[2] += int'(deisolate_out === 1'b1);
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			end_sim();
		end
	end

	// ====================================================
	// Tests
	initial begin
		rst_in = 1'b1;
		{alarm_any_in, alarm_unacked_in, displayed_iso_in, buzz_on_alarm_in, door_open_in, aux_line_fault_in} = '0;
		set_cond(8'h00);
		{mains_ok_in, battery_ok_in} = 2'b11;
		psu_mv_in = 16'h6978;
		step(8);
		rst_in = 1'b0;
		step(2);
		for (int i = 0; i < 8; i++) begin
			set_cond(8'h01 << i);
			step(2);
			check("lamp", leds_out, 32'h0001 << lmap[i]);
		end
		set_cond(8'h00);
		for (int i = 0; i < 6; i++) begin
			psu_mv_in = (i < 4) ? 16'(mvt[i]) : 16'h6978;
			mains_ok_in = (i != 4);
			battery_ok_in = (i != 5);
			step(2);
			check("psu", leds_out.psu_fault, (i == 0 || i > 2));
		end
		{alarm_any_in, alarm_unacked_in, aux_line_fault_in, buzz_on_alarm_in} = 4'b1111;
		step(2);
		lit(15, n);
		check("alarm_flash", n, 32'h0008);
		lit(8, n);
		check("aux_flash", n, 32'h0008);
		check("buzz_alarm", buzzer_out, 1'b1);
		{alarm_unacked_in, aux_line_fault_in} = 2'b00;
		step(2);
		check("buzz_quiet", buzzer_out, 1'b0);
		lit(15, n);
		check("alarm_steady", n, 32'h0010);
		check("aux_clear", leds_out.aux_fault, 1'b0);
		alarm_any_in = 1'b0;
		set_cond(8'h80);
		step(3);
		check("buzz", buzzer_out, 1'b1);
		pc[0] = 0;
		host.press(2, 8);
		check("ack", pc[0], 1);
		check("buzz_off", buzzer_out, 1'b0);
		set_cond(8'h00);
		for (int i = 0; i < 4; i++) begin
			host.press(9 - i, 8);
			check("iso_on", leds_out[12 - i], 1'b1);
			host.press(9 - i, 8);
			check("iso_off", leds_out[12 - i], 1'b0);
		end
		host.press(5, 8);
		check("invest", leds_out.investigate, 1'b1);
		host.press(3, 8);
		host.press(3, 8);
		host.press(4, 8);
		check("index", index_out, 8'h01);
		pc = '{0, 0, 0};
		host.press(1, 8);
		check("index_rst", index_out, `APIC_IDX_RST);
		check("rst_pulse", pc[1], 1);
		host.press(0, 8);
		displayed_iso_in = 1'b1;
		host.press(0, 8);
		check("deiso", pc[2], 1);
		door_open_in = 1'b1;
		step(8);
		check("door", leds_out.aux_iso, 1'b1);
		door_open_in = 1'b0;
		host.strobe(5, 8'h5a);
		step(1);
		check("type", {type_valid_out, running_out, board_type_out}, {2'b10, 8'h5a});
		host.strobe(2, 8'h00);
		check("run", running_out, 1'b1);
		host.strobe(3, 8'hc3);
		host.strobe(3, 8'h11);
		check("to_main", {to_main_full_out, to_main_out}, {1'b1, 8'hc3});
		host.strobe(1, 8'h00);
		check("to_main_rd", to_main_full_out, 1'b0);
		host.strobe(0, 8'ha1);
		host.strobe(0, 8'hb2);
		host.strobe(0, 8'h77);
		check("from_main", {from_main_ready_out, from_main_out}, {1'b1, 16'ha1b2});
		host.strobe(4, 8'h00);
		check("from_main_take", from_main_ready_out, 1'b0);
		end_sim();
	end
endmodule
